//--- logic/upm_pkg.sv
// package: register offsets, field positions, reset values, timing and carrier types
package upm_pkg;

    // register offsets on the three address lines
    localparam logic [2:0] OFS_0 = 3'h0;
    localparam logic [2:0] OFS_1 = 3'h1;
    localparam logic [2:0] OFS_2 = 3'h2;
    localparam logic [2:0] OFS_3 = 3'h3;
    localparam logic [2:0] OFS_4 = 3'h4;
    localparam logic [2:0] OFS_5 = 3'h5;
    localparam logic [2:0] OFS_6 = 3'h6;
    localparam logic [2:0] OFS_7 = 3'h7;

    // line-control value that opens the enhanced bank
    localparam logic [7:0] ENH_KEY = 8'hBF;

    // field positions
    localparam int LC_DIV_BIT    = 7;
    localparam int EF_ENH_BIT    = 4;
    localparam int FC_SEL_BIT    = 6;
    localparam int IE_SLEEP_BIT  = 4;
    localparam int MC_LOOP_BIT   = 4;

    // reset values
    localparam logic [7:0] RST_LINE_CONTROL = 8'h00;
    localparam logic [7:0] RST_REG          = 8'h00;
    localparam logic [7:0] RST_DIVISOR      = 8'h00;
    localparam logic [3:0] ISR_NONE         = 4'h1;

    // timing
    localparam int  CLK_HZ        = 50_000_000;
    localparam int  IDLE_SEC      = 30;
    localparam int  PUMP_REC_NS   = 45_000;
    localparam int  CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam longint IDLE_CYCLES = longint'(IDLE_SEC) * longint'(CLK_HZ);
    localparam int  PUMP_REC_CYCLES = (PUMP_REC_NS + CLK_NS - 1) / CLK_NS;

    // host bus request, sampled each clock
    typedef struct packed {
        logic       cs;
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } upm_bus_t;

    // serial and modem pins
    typedef struct packed {
        logic       rx;
        logic [3:0] modem;
    } upm_line_t;

endpackage

//--- logic/upm_regmem.sv
// small register memory holding the plain read/write bytes of both banks
`timescale 1ns/1ns
module upm_regmem
    import upm_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    // write port
    input  wire logic                     wr_en_i,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input  wire logic [7:0]               wr_data_i,
    // read port, data registered
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic      [7:0]               rd_data_o
);
    logic [DEPTH-1:0][7:0] mem;

    // storage and registered read; reset clears every byte
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mem       <= '0;
            rd_data_o <= RST_REG;
        end else begin
            if (wr_en_i) begin
                mem[wr_addr_i] <= wr_data_i;
            end
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

//--- logic/upm_core.sv
// power-mode control and register decode for the single-channel uart
//
// Contract
// - pump off after tx quiet, modem idle
// - pump off: drivers tri-state, registers stay
// - rx start, tx write, modem rise wake
// - drivers not ready 45us after restart
// - pump off at once while asleep
// - power-save needs isolate pin and sleep
// - power-save wakes only by rx, modem
// - re-enter power-save after status serviced
// - power-save ends: sleep bit clear, pin low
// - wake interrupt once oscillator is ready
// - wake code 0x1, cleared by status read
// - modem-control bit 4 loops tx to rx
// - three address lines with chip select
// - offset 0 holding regs, divisor bit clear
// - divisor bytes behind line-control bit 7
// - zero divisor shows revision, identification
// - offsets 1, 2 enable and status
// - line, modem control and status map
// - offset 7 scratch or level select
// - key 0xBF opens enhanced bank
// - sleep needs idle, divisor, enable, quiet
`timescale 1ns/1ns
module upm_core
    import upm_pkg::*;
#(
    parameter longint IDLE_CNT = IDLE_CYCLES,
    parameter int     REC_CNT  = PUMP_REC_CYCLES,
    parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
    parameter logic [7:0] ID_CODE  = 8'h5A  // arbitrary value
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // host bus, strobes active low
    input  wire logic       chip_select_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic       write_strobe_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_n_o,
    // mode pins
    input  wire logic       auto_pump_shutdown_pin_i,
    input  wire logic       bus_isolate_pin_i,
    input  wire logic       osc_ready_i,
    // serial side
    input  wire logic       rx_i,
    input  wire logic [3:0] modem_i,
    input  wire logic       tx_shift_i,
    input  wire logic       tx_active_i,
    input  wire logic       uart_irq_pending_i,
    // outputs
    output logic            rx_shift_o,
    output logic            tx_line_o,
    output logic            tx_line_oe_n_o,
    output logic            pump_on_o,
    output logic            drivers_ready_o,
    output logic            sleep_o,
    output logic            power_save_o,
    output logic            tx_load_o,
    output logic [7:0]      tx_data_o
);
    typedef enum logic [1:0] {PS_ACTIVE, PS_SLEEP, PS_SAVE} upm_pwr_t;
    typedef enum logic [1:0] {PU_ON, PU_OFF, PU_RECOVER} upm_pump_t;

    // whole module state
    typedef struct packed {
        logic [2:0]  rx_s;
        logic [2:0][3:0] md_s;
        logic [2:0]  apsd_s;
        logic [2:0]  iso_s;
        logic [2:0]  osc_s;
        logic        rx_q;
        logic [3:0]  md_q;
        upm_bus_t    bus;
        logic        rd_q;
        logic        wr_q;
        logic [7:0]  line_control;
        logic [7:0]  interrupt_enable;
        logic [7:0]  modem_control;
        logic [7:0]  feature_control;
        logic [7:0]  enhanced_function;
        logic [7:0]  divisor_low;
        logic [7:0]  divisor_high;
        logic [3:0]  msr_delta;
        logic        wake_irq;
        logic        wake_pend;
        upm_pwr_t    pwr;
        upm_pump_t   pump;
        logic [35:0] idle_cnt;
        logic [15:0] rec_cnt;
        logic [7:0]  data_o;
        logic        oe_n;
        logic        rx_shift;
        logic        tx_line;
        logic        tx_oe_n;
        logic        tx_load;
        logic [7:0]  tx_data;
        logic        sel_mem;
        logic [7:0]  direct;
    } upm_state_t;

    upm_state_t s;
    upm_state_t next_s;

    // memory holding scratch, xon/xoff, trigger, fraction, fifo control, mode select
    logic       mem_we;
    logic [3:0] mem_waddr;
    logic [3:0] mem_raddr;
    logic [7:0] mem_rdata;

    upm_regmem #(.DEPTH(16)) u_mem (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .wr_en_i   (mem_we),
        .wr_addr_i (mem_waddr),
        .wr_data_i (s.bus.wdata),
        .rd_addr_i (mem_raddr),
        .rd_data_o (mem_rdata)
    );

    // stable synchroniser output: second and third stages agree
    function automatic logic stable(input logic [2:0] sh, input logic prev);
        stable = (sh[1] == sh[2]) ? sh[2] : prev;
    endfunction

    // memory slot for a bank/offset pair
    function automatic logic [3:0] slot(input logic enh, input logic [2:0] ofs);
        slot = {enh, ofs};
    endfunction

    logic       enh;
    logic       div_acc;
    logic       div_zero;
    logic       rx_now;
    logic [3:0] md_now;
    logic       rx_start;
    logic [3:0] md_rise;
    logic [3:0] md_change;
    logic       take_rd;
    logic       take_wr;
    logic       tx_write;
    logic       asleep;
    logic       sleep_ok;
    logic       wake_evt;

    always_comb begin
        next_s    = s;
        mem_we    = 1'b0;
        mem_waddr = 4'h0;
        mem_raddr = 4'h0;
        tx_write  = 1'b0;

        // pins pass three flops; a level counts once stages two and three agree
        next_s.rx_s   = {s.rx_s[1:0], rx_i};
        next_s.md_s   = {s.md_s[1:0], modem_i};
        next_s.apsd_s = {s.apsd_s[1:0], auto_pump_shutdown_pin_i};
        next_s.iso_s  = {s.iso_s[1:0], bus_isolate_pin_i};
        next_s.osc_s  = {s.osc_s[1:0], osc_ready_i};
        rx_now = stable(s.rx_s, s.rx_q);
        for (int i = 0; i < 4; i++) begin
            md_now[i] = (s.md_s[1][i] == s.md_s[2][i]) ? s.md_s[2][i] : s.md_q[i];
        end
        next_s.rx_q = rx_now;
        next_s.md_q = md_now;
        rx_start  = rx_now & ~s.rx_q;              // edge as the line wakes
        md_rise   = md_now & ~s.md_q;
        md_change = md_now ^ s.md_q;

        enh      = (s.line_control == ENH_KEY);
        div_acc  = s.line_control[LC_DIV_BIT] && !enh;
        div_zero = (s.divisor_low == RST_DIVISOR) && (s.divisor_high == RST_DIVISOR);
        asleep   = (s.pwr != PS_ACTIVE);

        // bus isolated in power-save: strobes never reach the core
        next_s.bus.cs    = !chip_select_n_i;
        next_s.bus.rd    = !read_strobe_n_i;
        next_s.bus.wr    = !write_strobe_n_i;
        next_s.bus.addr  = addr_i;
        next_s.bus.wdata = data_i;
        next_s.rd_q = s.bus.cs & s.bus.rd;
        next_s.wr_q = s.bus.cs & s.bus.wr;
        take_rd = s.bus.cs & s.bus.rd & !s.rd_q & (s.pwr != PS_SAVE);
        take_wr = s.bus.cs & s.bus.wr & !s.wr_q & (s.pwr != PS_SAVE);

        // modem delta bits: set wins over the clear on read
        if (take_rd && s.bus.addr == OFS_6 && !enh) begin
            next_s.msr_delta = md_change;
        end else begin
            next_s.msr_delta = s.msr_delta | md_change;
        end

        // writes; all registers stay reachable with the pump off
        if (take_wr) begin
            case (s.bus.addr)
                OFS_0: begin
                    if (div_acc) begin
                        next_s.divisor_low = s.bus.wdata;
                    end else if (enh) begin
                        mem_we = 1'b1;
                        mem_waddr = slot(1'b1, OFS_0);
                    end else begin
                        tx_write = 1'b1;
                    end
                end
                OFS_1: begin
                    if (enh) begin
                        next_s.feature_control = s.bus.wdata;
                    end else if (div_acc) begin
                        next_s.divisor_high = s.bus.wdata;
                    end else begin
                        next_s.interrupt_enable = s.bus.wdata;
                    end
                end
                OFS_2: begin
                    if (enh) begin
                        next_s.enhanced_function = s.bus.wdata;
                    end else if (!(div_acc && s.enhanced_function[EF_ENH_BIT])) begin
                        mem_we = 1'b1;
                        mem_waddr = slot(1'b0, OFS_2);
                    end else begin
                        mem_we = 1'b1;
                        mem_waddr = slot(1'b1, OFS_3);
                    end
                end
                OFS_3: next_s.line_control = s.bus.wdata;
                OFS_4: begin
                    if (enh) begin
                        mem_we = 1'b1;
                        mem_waddr = slot(1'b1, OFS_4);
                    end else begin
                        next_s.modem_control = s.bus.wdata;
                    end
                end
                OFS_7: begin
                    mem_we = 1'b1;
                    mem_waddr = slot(enh, (!enh && s.feature_control[FC_SEL_BIT])
                                          ? OFS_1 : OFS_7);
                end
                default: begin
                    if (enh) begin
                        mem_we = 1'b1;
                        mem_waddr = slot(1'b1, s.bus.addr);
                    end
                end
            endcase
        end
        next_s.tx_load = tx_write;
        next_s.tx_data = tx_write ? s.bus.wdata : s.tx_data;

        // read mux; memory bytes are presented one cycle later
        next_s.sel_mem = 1'b0;
        next_s.direct  = 8'h00;
        mem_raddr = slot(enh, s.bus.addr);
        case (s.bus.addr)
            OFS_0: begin
                if (div_acc) begin
                    next_s.direct = div_zero ? REV_CODE : s.divisor_low;
                end else begin
                    next_s.sel_mem = enh;                          // rx holding is outside
                end
            end
            OFS_1: begin
                if (enh) begin
                    next_s.direct = s.feature_control;
                end else if (div_acc) begin
                    next_s.direct = div_zero ? ID_CODE : s.divisor_high;
                end else begin
                    next_s.direct = s.interrupt_enable;
                end
            end
            OFS_2: begin
                if (enh) begin
                    next_s.direct = s.enhanced_function;
                end else if (div_acc && s.enhanced_function[EF_ENH_BIT]) begin
                    next_s.sel_mem = 1'b1;
                    mem_raddr = slot(1'b1, OFS_3);
                end else begin
                    next_s.direct = {4'h0, s.wake_irq ? ISR_NONE : 4'h1};
                end
            end
            OFS_3: next_s.direct = s.line_control;
            OFS_4: begin
                next_s.sel_mem = enh;
                next_s.direct  = s.modem_control;
            end
            OFS_5: next_s.sel_mem = enh;                           // line status is outside
            OFS_6: begin
                next_s.sel_mem = enh;
                next_s.direct  = {md_now, s.msr_delta};
            end
            default: next_s.sel_mem = enh || !s.feature_control[FC_SEL_BIT];
        endcase
        next_s.data_o = s.sel_mem ? mem_rdata : s.direct;
        next_s.oe_n   = !(take_rd || (s.bus.cs & s.bus.rd & s.rd_q & (s.pwr != PS_SAVE)));

        // wake interrupt clears on a status read, the raise wins
        if (take_rd && s.bus.addr == OFS_2 && !enh && !div_acc) begin
            next_s.wake_irq = 1'b0;
        end
        // raised once the oscillator is running again
        if (s.wake_pend && stable(s.osc_s, 1'b0)) begin
            next_s.wake_irq  = 1'b1;
            next_s.wake_pend = 1'b0;
        end

        // sleep entry condition
        sleep_ok = !uart_irq_pending_i && !s.wake_irq && !div_zero
                   && s.interrupt_enable[IE_SLEEP_BIT] && (s.msr_delta == 4'h0)
                   && rx_now && !tx_active_i;
        wake_evt = rx_start || (md_change != 4'h0) || tx_write;

        // power state machine
        case (s.pwr)
            PS_ACTIVE: begin
                if (sleep_ok && !wake_evt) begin
                    next_s.pwr = PS_SLEEP;
                end
            end
            PS_SLEEP: begin
                if (wake_evt || !s.interrupt_enable[IE_SLEEP_BIT]) begin
                    next_s.pwr = PS_ACTIVE;
                    next_s.wake_pend = s.interrupt_enable[IE_SLEEP_BIT];
                end else if (s.iso_s[2] && s.iso_s[1]) begin
                    next_s.pwr = PS_SAVE;
                end
            end
            PS_SAVE: begin
                if (rx_start || (md_change != 4'h0)) begin
                    next_s.pwr = PS_ACTIVE;
                    next_s.wake_pend = 1'b1;
                end else if (!s.interrupt_enable[IE_SLEEP_BIT]
                             || (!s.iso_s[2] && !s.iso_s[1])) begin
                    next_s.pwr = PS_ACTIVE;
                end
            end
            default: next_s.pwr = PS_ACTIVE;
        endcase

        // idle timer restarts on any modem or transmit activity
        if (md_change != 4'h0 || tx_active_i || tx_write || s.pump != PU_ON) begin
            next_s.idle_cnt = '0;
        end else if (s.idle_cnt < 36'(IDLE_CNT)) begin
            next_s.idle_cnt = s.idle_cnt + 36'h1;
        end

        // charge pump machine
        case (s.pump)
            PU_ON: begin
                if (s.apsd_s[2] && s.apsd_s[1]) begin
                    if (asleep) begin
                        next_s.pump = PU_OFF;
                    end else if (s.idle_cnt >= 36'(IDLE_CNT) && !tx_active_i) begin
                        next_s.pump = PU_OFF;
                    end
                end
            end
            PU_OFF: begin
                // a rising line, a new byte or a modem rise restarts it
                if (rx_start || (md_rise != 4'h0) || tx_write
                    || (!s.apsd_s[2] && !s.apsd_s[1])) begin
                    next_s.pump    = PU_RECOVER;
                    next_s.rec_cnt = '0;
                end
            end
            PU_RECOVER: begin
                if (s.rec_cnt >= 16'(REC_CNT - 1)) begin
                    next_s.pump = PU_ON;
                end else begin
                    next_s.rec_cnt = s.rec_cnt + 16'h1;
                end
            end
            default: next_s.pump = PU_ON;
        endcase

        // loopback routes the shift output back to the receiver
        if (s.modem_control[MC_LOOP_BIT]) begin
            next_s.rx_shift = tx_shift_i;
            next_s.tx_line  = 1'b1;
        end else begin
            next_s.rx_shift = rx_now;
            next_s.tx_line  = tx_shift_i;
        end
        // drivers float unless the pump is fully up
        next_s.tx_oe_n = (next_s.pump != PU_ON);
    end

    // state register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.rx_s  <= 3'h7;
            s.rx_q  <= 1'b1;
            s.line_control <= RST_LINE_CONTROL;
            s.pwr   <= PS_ACTIVE;
            s.pump  <= PU_ON;
            s.oe_n  <= 1'b1;
            s.tx_line <= 1'b1;
            s.rx_shift <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state flops
    assign data_o          = s.data_o;
    assign data_oe_n_o     = s.oe_n;
    assign rx_shift_o      = s.rx_shift;
    assign tx_line_o       = s.tx_line;
    assign tx_line_oe_n_o  = s.tx_oe_n;
    assign pump_on_o       = (s.pump != PU_OFF);
    assign drivers_ready_o = !s.tx_oe_n;
    assign sleep_o         = (s.pwr != PS_ACTIVE);
    assign power_save_o    = (s.pwr == PS_SAVE);
    assign tx_load_o       = s.tx_load;
    assign tx_data_o       = s.tx_data;
endmodule

//--- testbench/upm_host.sv
// host model: drives the register bus one byte at a time
`timescale 1ns/1ns
module upm_host #(
    parameter int REC = 10
) (
    // clock and read data
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] data_i,
    // bus lines, strobes low active
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic      [2:0] addr_o,
    output logic      [7:0] wdata_o
);
    // bus idle at time zero
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 3'h0;
        wdata_o = 8'h00;
    end

    // strobe held four edges; read data taken at the closing edge
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] v,
                       output logic [7:0] q);
        @(posedge clk_sys_i);
        cs_n_o  <= 1'b0;
        rd_n_o  <= w;
        wr_n_o  <= !w;
        addr_o  <= a;
        wdata_o <= v;
        repeat (4) @(posedge clk_sys_i);
        q = data_i;
        cs_n_o  <= 1'b1;
        rd_n_o  <= 1'b1;
        wr_n_o  <= 1'b1;
        wdata_o <= ~v; // released bus shows the inverse, not the old byte
    endtask

    // hold off transmission while the pump recovers
    task automatic pump_wait;
        repeat (REC + 4) @(posedge clk_sys_i);
    endtask
endmodule

//--- testbench/upm_core_asserts.sv
// checker: pump, power-save and bus properties of the core
`timescale 1ns/1ns
module upm_core_asserts (
    // clock, reset and inputs
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic auto_pump_shutdown_pin_i,
    input wire logic bus_isolate_pin_i,
    // observed outputs
    input wire logic data_oe_n_o,
    input wire logic tx_line_oe_n_o,
    input wire logic pump_on_o,
    input wire logic drivers_ready_o,
    input wire logic sleep_o,
    input wire logic power_save_o,
    input wire logic tx_load_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // pump and driver relations
    property p_pin_low; !auto_pump_shutdown_pin_i [*5] |-> pump_on_o; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pump off with pin low");
    property p_float; !pump_on_o |-> tx_line_oe_n_o; endproperty
    a_float: assert property (p_float) else $error("drivers on with pump off");
    property p_rec_hold; $rose(pump_on_o) |-> !drivers_ready_o [*8]; endproperty
    a_rec_hold: assert property (p_rec_hold) else $error("drivers ready too soon");
    property p_rec_done; $rose(pump_on_o) |-> ##[9:20] (drivers_ready_o || !pump_on_o);
    endproperty
    a_rec_done: assert property (p_rec_done) else $error("drivers never ready");
    // a wake by rx start, tx write or modem rise raises the pump on the same edge that sleep drops
    property p_sleep_pump;
        (sleep_o && auto_pump_shutdown_pin_i) [*5] |-> !pump_on_o || $rose(pump_on_o);
    endproperty
    a_sleep_pump: assert property (p_sleep_pump) else $error("pump on while asleep");
    // power-save relations
    property p_save_sleep; power_save_o |-> sleep_o; endproperty
    a_save_sleep: assert property (p_save_sleep) else $error("save without sleep");
    property p_save_quiet; power_save_o [*4] |-> !tx_load_o; endproperty
    a_save_quiet: assert property (p_save_quiet) else $error("bus write taken in save");
    property p_save_exit; !bus_isolate_pin_i [*6] |-> !power_save_o; endproperty
    a_save_exit: assert property (p_save_exit) else $error("save with pin low");
    // bus answers follow their strobes
    property p_rd_oe;
        !data_oe_n_o |-> !($past(read_strobe_n_i, 2) && $past(read_strobe_n_i, 3));
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("data driven without read");
    property p_load_wr; tx_load_o |-> !$past(write_strobe_n_i, 2); endproperty
    a_load_wr: assert property (p_load_wr) else $error("load without write");
endmodule

bind upm_core upm_core_asserts u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .read_strobe_n_i(read_strobe_n_i),
    .write_strobe_n_i(write_strobe_n_i), .auto_pump_shutdown_pin_i(auto_pump_shutdown_pin_i),
    .bus_isolate_pin_i(bus_isolate_pin_i), .data_oe_n_o(data_oe_n_o),
    .tx_line_oe_n_o(tx_line_oe_n_o), .pump_on_o(pump_on_o), .drivers_ready_o(drivers_ready_o),
    .sleep_o(sleep_o), .power_save_o(power_save_o), .tx_load_o(tx_load_o)
);

//--- testbench/upm_core_test.sv
// testbench: register map, loopback, pump and power-save scenarios
`timescale 1ns/1ns
module upm_core_test;
    import upm_pkg::*;
    localparam int REC = 10;
    localparam logic [7:0] REV = 8'h3C; // arbitrary value
    localparam logic [7:0] ID  = 8'hC3; // arbitrary value
    logic       clk_sys_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       cs_n, rd_n, wr_n, oe_n, rx_sh, txl, txoe, pump, rdy, slp, psv, tld;
    logic [2:0] addr;
    logic [7:0] wdata, dout, txd, q, last_tx;
    logic       apsd = 1'b0, iso = 1'b0, rx = 1'b1, tsh = 1'b1;
    logic [3:0] modem = 4'h0;
    int         miscompares = 0, checks = 0, cyc = 0, loads = 0;

    always #10 clk_sys_i = ~clk_sys_i;
    upm_host #(.REC(REC)) u_host (.clk_sys_i(clk_sys_i), .data_i(dout), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
    upm_core #(.IDLE_CNT(100), .REC_CNT(REC), .REV_CODE(REV), .ID_CODE(ID)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(dout),
        .data_oe_n_o(oe_n), .auto_pump_shutdown_pin_i(apsd), .bus_isolate_pin_i(iso),
        .osc_ready_i(1'b1), .rx_i(rx), .modem_i(modem), .tx_shift_i(tsh), .tx_active_i(1'b0),
        .uart_irq_pending_i(1'b0), .rx_shift_o(rx_sh), .tx_line_o(txl),
        .tx_line_oe_n_o(txoe), .pump_on_o(pump), .drivers_ready_o(rdy), .sleep_o(slp),
        .power_save_o(psv), .tx_load_o(tld), .tx_data_o(txd));

    // hang guard and capture of every transmit load pulse
    always @(posedge clk_sys_i) begin
        cyc++;
        if (tld === 1'b1) begin
            loads++;
            last_tx = txd;
        end
        if (cyc == 4000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [2:0] a, input logic [7:0] v);
        u_host.acc(1'b1, a, v, q);
    endtask
    task automatic r(input string n, input logic [2:0] a, input logic [7:0] e);
        u_host.acc(1'b0, a, 8'h00, q);
        chk(n, e, q);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // plain, divisor and enhanced banks; divisor still zero shows the codes
    task automatic t_regs;
        chk("oe idle", 8'h01, {7'h0, oe_n});
        w(OFS_3, 8'h03);
        r("lcr", OFS_3, 8'h03);
        w(OFS_1, 8'h0A);
        r("ier", OFS_1, 8'h0A);
        w(OFS_4, 8'h0B);
        r("mcr", OFS_4, 8'h0B);
        w(OFS_7, 8'h5C);
        r("spr", OFS_7, 8'h5C);
        u_host.acc(1'b0, OFS_2, 8'h00, q);
        chk("isr", 8'h01, {4'h0, q[3:0]});
        w(OFS_0, 8'hA7);
        tick(2);
        chk("tx", 8'hA7, last_tx);
        w(OFS_3, 8'h83);
        r("rev", OFS_0, REV);
        r("id", OFS_1, ID);
        w(OFS_0, 8'h0C);
        r("dll", OFS_0, 8'h0C);
        r("dlm", OFS_1, 8'h00);
        w(OFS_3, 8'hBF);
        w(OFS_4, 8'h11);
        r("xon", OFS_4, 8'h11);
        w(OFS_2, 8'h10);
        r("efr", OFS_2, 8'h10);
        w(OFS_3, 8'h83);
        w(OFS_2, 8'h66);
        r("frac", OFS_2, 8'h66);
        w(OFS_3, 8'h03);
        $display("regs done");
    endtask

    // loopback routes the shift output back and parks the line high
    task automatic t_loop;
        w(OFS_4, 8'h10);
        tsh <= 1'b0;
        tick(4);
        chk("loop0", 8'h00, {7'h0, rx_sh});
        chk("line", 8'h01, {7'h0, txl});
        tsh <= 1'b1;
        tick(4);
        chk("loop1", 8'h01, {7'h0, rx_sh});
        w(OFS_4, 8'h00);
        $display("loop done");
    endtask

    // idle shutdown, then each wake event in turn
    task automatic t_pump;
        apsd <= 1'b1;
        tick(160);
        chk("idle off", 8'h00, {7'h0, pump});
        chk("float", 8'h01, {7'h0, txoe});
        r("spr off", OFS_7, 8'h5C);
        modem <= 4'h1;
        tick(6);
        chk("modem wake", 8'h01, {7'h0, pump});
        chk("not ready", 8'h00, {7'h0, rdy});
        u_host.pump_wait();
        chk("ready", 8'h01, {7'h0, rdy});
        tick(160);
        rx <= 1'b0; // start bit
        tick(4);
        rx <= 1'b1;
        tick(6);
        chk("rx wake", 8'h01, {7'h0, pump});
        tick(160);
        w(OFS_0, 8'h3E);
        tick(2);
        chk("tx wake", 8'h01, {7'h0, pump});
        u_host.pump_wait();
        $display("pump done");
    endtask

    // sleep with both pins high, ignored write, modem wake, re-entry, pin release
    task automatic t_save;
        iso <= 1'b1;
        u_host.acc(1'b0, OFS_6, 8'h00, q);
        u_host.acc(1'b0, OFS_2, 8'h00, q);
        w(OFS_1, 8'h10);
        tick(20);
        chk("sleep", 8'h01, {7'h0, slp});
        chk("sleep pump", 8'h00, {7'h0, pump});
        chk("save", 8'h01, {7'h0, psv});
        w(OFS_7, 8'hE1);
        modem <= 4'h3;
        tick(8);
        chk("save wake", 8'h00, {7'h0, psv});
        u_host.pump_wait();
        r("spr kept", OFS_7, 8'h5C);
        u_host.acc(1'b0, OFS_2, 8'h00, q);
        chk("wake isr", 8'h01, {4'h0, q[3:0]});
        u_host.acc(1'b0, OFS_6, 8'h00, q);
        tick(20);
        chk("resave", 8'h01, {7'h0, psv});
        iso <= 1'b0;
        tick(8);
        chk("save off", 8'h00, {7'h0, psv});
        $display("save done");
    endtask

    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(6);
        rst_i <= 1'b0;
        tick(4);
        t_regs();
        t_loop();
        t_pump();
        t_save();
        results();
    end
endmodule
